// ==== dv/pms_seq_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module pms_seq_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic supply_ok_i,
  input wire logic brownout_i,
  input wire logic cpu_idle_i,
  input wire logic [1:0] mode_req_i,
  input wire logic [7:0] irq_i,
  input wire logic [7:0] irq_en_i,
  input wire logic sys_rst_o,
  input wire logic cpu_clk_en_o,
  input wire logic periph_clk_en_o,
  input wire logic hs_osc_en_o,
  input wire logic lf_osc_en_o,
  input wire logic cpu_pwr_en_o,
  input wire logic addr_watch_o,
  input wire logic cpu_wake_o,
  input wire logic [1:0] mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Cycles of a deep wake-up with the fast oscillator on; saturates so a hang still fails
  logic [11:0] wake_cyc;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_cyc <= 12'h000;
    end else if (mode_o == 2'h2 && hs_osc_en_o) begin
      if (wake_cyc != 12'hfff) begin
        wake_cyc <= wake_cyc + 12'h001;
      end
    end else begin
      wake_cyc <= 12'h000;
    end
  end
  AST_LF_RUN: assert property (lf_osc_en_o)
    else $error("low clock stopped");
  AST_BROWN: assert property (brownout_i |=> sys_rst_o)
    else $error("no reset on brownout");
  AST_SUPPLY: assert property (!supply_ok_i |=> sys_rst_o && !cpu_clk_en_o)
    else $error("running without supply");
  AST_ACTIVE: assert property (mode_o == 2'h0 && !sys_rst_o |->
    cpu_clk_en_o && periph_clk_en_o && hs_osc_en_o && cpu_pwr_en_o)
    else $error("active clocks off");
  AST_SLEEP: assert property (mode_o == 2'h1 |-> !cpu_clk_en_o && periph_clk_en_o)
    else $error("sleep gating wrong");
  AST_DEEP_IN: assert property ($rose(mode_o == 2'h2) |-> !hs_osc_en_o &&
    !periph_clk_en_o && !cpu_pwr_en_o && addr_watch_o)
    else $error("deep entry wrong");
  AST_WAKE_LIM: assert property (wake_cyc <= 12'h06d4)
    else $error("deep wake too slow");
  AST_SLEEP_WAKE: assert property (mode_o == 2'h1 && |(irq_i & irq_en_i) |->
    ##[1:2] mode_o == 2'h0 && cpu_clk_en_o)
    else $error("sleep wake late");
  AST_PULSE: assert property (cpu_wake_o |-> mode_o == 2'h0 &&
    $past(mode_o) != 2'h0 ##1 !cpu_wake_o)
    else $error("wake pulse wrong");
  AST_ENTER: assert property (mode_o == 2'h0 && !sys_rst_o && cpu_idle_i &&
    mode_req_i == 2'h1 |-> ##[1:2] mode_o == 2'h1)
    else $error("sleep not entered");
  CV_SLEEP: cover property (mode_o == 2'h1 ##1 mode_o == 2'h0);
  CV_DEEP: cover property ($fell(mode_o == 2'h2));
  CV_BROWN: cover property (brownout_i ##1 sys_rst_o);
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'h0, rst_i = 1'h1, supply_ok_i = 1'h0, brownout_i = 1'h0;
  logic hs_osc_ready_i = 1'h0, cpu_idle_i = 1'h1, addr_match_i = 1'h0;
  logic [1:0] mode_req_i = 2'h0;
  logic [7:0] irq_i = 8'h00, irq_en_i = 8'h00;
  wire [7:0] irq_pend_o;
  wire sys_rst_o, cpu_clk_en_o, periph_clk_en_o, hs_osc_en_o, lf_osc_en_o;
  wire cpu_pwr_en_o, addr_watch_o, cpu_wake_o, wake_late_o;
  wire [1:0] mode_o;
  wire [8:0] wake_cause_o;
  int error_cnt = 0, checks_done = 0;
  always #10 clk_i = ~clk_i;
  pms_sequencer dut_u (.clk_i, .rst_i, .supply_ok_i, .brownout_i, .hs_osc_ready_i,
    .cpu_idle_i, .mode_req_i, .irq_i, .irq_en_i, .addr_match_i, .sys_rst_o, .cpu_clk_en_o,
    .periph_clk_en_o, .hs_osc_en_o, .lf_osc_en_o, .cpu_pwr_en_o, .addr_watch_o,
    .irq_pend_o, .cpu_wake_o, .mode_o, .wake_cause_o, .wake_late_o);
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // Sample 1 ns after the edge so registered outputs have landed
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_mode(input logic [1:0] m, output int n);
    n = 0;
    while (mode_o !== m) begin
      step();
      n++;
      if (n > 2000) begin
        error_cnt++;
        final_report();
      end
    end
  endtask
  task automatic t_power;
    step(20);
    rst_i <= 1'h0;
    step(30);
    chk(sys_rst_o, 1'h1);
    chk(lf_osc_en_o, 1'h1);
    supply_ok_i <= 1'h1;
    step(8);
    chk(sys_rst_o, 1'h1);
    step(4);
    chk({sys_rst_o, cpu_clk_en_o, periph_clk_en_o, hs_osc_en_o, cpu_pwr_en_o}, 5'h0f);
    $display("power done");
  endtask
  task automatic t_sleep;
    irq_en_i <= 8'h01;
    mode_req_i <= 2'h1;
    step(2);
    mode_req_i <= 2'h0;
    chk({mode_o, cpu_clk_en_o, periph_clk_en_o}, 4'h5);
    irq_i <= 8'h02;
    step(3);
    chk(mode_o, 2'h1);
    irq_i <= 8'h03;
    step();
    chk({mode_o, cpu_clk_en_o, cpu_wake_o}, 4'h3);
    step();
    chk({cpu_wake_o, irq_pend_o}, 9'h001);
    mode_req_i <= 2'h2;
    step(4);
    chk(mode_o, 2'h0);
    mode_req_i <= 2'h0;
    step();
    irq_i <= 8'h00;
    step(2);
    $display("sleep done");
  endtask
  task automatic t_deep;
    int n;
    logic [8:0] src;
    irq_en_i <= 8'hff;
    for (int i = 0; i < 9; i++) begin
      src = 9'h001 << i;
      hs_osc_ready_i <= (i != 0);
      mode_req_i <= 2'h2;
      step(2);
      mode_req_i <= 2'h0;
      chk({mode_o, hs_osc_en_o, periph_clk_en_o, cpu_pwr_en_o, addr_watch_o}, 6'h21);
      step(5);
      {addr_match_i, irq_i} <= src;
      wait_mode(2'h0, n);
      chk(n <= 1750, 1'h1);
      chk(wake_cause_o, src);
      chk({wake_late_o, cpu_wake_o}, {i == 0, 1'h1});
      {addr_match_i, irq_i} <= 9'h000;
      step(3);
    end
    $display("deep done");
  endtask
  task automatic t_brown;
    brownout_i <= 1'h1;
    step();
    chk({sys_rst_o, cpu_clk_en_o, hs_osc_en_o, cpu_pwr_en_o}, 4'h8);
    brownout_i <= 1'h0;
    step(14);
    chk({sys_rst_o, cpu_clk_en_o}, 2'h1);
    $display("brownout done");
  endtask
  initial begin
    t_power();
    t_sleep();
    t_deep();
    t_brown();
    final_report();
  end
endmodule
bind pms_sequencer pms_seq_assertions chk_u (.clk_i, .rst_i, .supply_ok_i, .brownout_i,
  .cpu_idle_i, .mode_req_i, .irq_i, .irq_en_i, .sys_rst_o, .cpu_clk_en_o, .periph_clk_en_o,
  .hs_osc_en_o, .lf_osc_en_o, .cpu_pwr_en_o, .addr_watch_o, .cpu_wake_o, .mode_o);
`default_nettype wire

// ==== logic/pms_sequencer.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pms_map.vh"
// Notes on behaviour
// - Three modes only; Active keeps every subsystem clocked.
// - Sleep gates processor, flash, SRAM clocks; peripherals run; wake is immediate.
// - Deep Sleep switches off high-speed clock and its dependent circuitry.
// - Deep Sleep wake-up completes within 35 us of the wake event.
// - Wake-up interrupt unit stays alive in Deep Sleep and restarts processor.
// - Mode entry and reset release wait until supplies are adequate.
// - Brown-out report always produces a reset.
// - Any enabled interrupt can end Deep Sleep.
// - Serial address match in Deep Sleep raises a wake-up request.
// - Interrupt controller accepts eight request inputs.
// - Low-frequency oscillator keeps running in Deep Sleep for watchdog, peripherals.
module pms_sequencer (
  input wire clk_i,
  input wire rst_i,
  input wire supply_ok_i,
  input wire brownout_i,
  input wire hs_osc_ready_i,
  input wire cpu_idle_i,
  input wire [1:0] mode_req_i,
  input wire [`PMS_NUM_IRQ-1:0] irq_i,
  input wire [`PMS_NUM_IRQ-1:0] irq_en_i,
  input wire addr_match_i,
  output reg sys_rst_o,
  output reg cpu_clk_en_o,
  output reg periph_clk_en_o,
  output reg hs_osc_en_o,
  output reg lf_osc_en_o,
  output reg cpu_pwr_en_o,
  output reg addr_watch_o,
  output reg [`PMS_NUM_IRQ-1:0] irq_pend_o,
  output reg cpu_wake_o,
  output reg [1:0] mode_o,
  output reg [`PMS_NUM_IRQ:0] wake_cause_o,
  output reg wake_late_o
);
  localparam [5:0] ST_RESET = 6'h01;
  localparam [5:0] ST_ACTIVE = 6'h02;
  localparam [5:0] ST_SLEEP = 6'h04;
  localparam [5:0] ST_DEEP = 6'h08;
  localparam [5:0] ST_HS_START = 6'h10;
  localparam [5:0] ST_RESTORE = 6'h20;
  localparam [11:0] WAKE_MAX = `PMS_WAKE_MAX_CYC;

  reg [5:0] state;
  reg [5:0] next_state;
  reg [3:0] sup_cnt;
  reg sup_good;
  reg [11:0] wake_cnt;
  reg [11:0] hs_cnt;
  wire wake_any;
  wire irq_hit;
  wire [`PMS_NUM_IRQ:0] unit_cause;
  wire unit_watch;

  assign irq_hit = |(irq_i & irq_en_i);
  assign unit_watch = (state == ST_DEEP) || (state == ST_HS_START);

  pms_wake_unit u_wake (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .watch_i(unit_watch),
    .clear_i(state == ST_RESTORE),
    .irq_i(irq_i),
    .irq_en_i(irq_en_i),
    .addr_match_i(addr_match_i & addr_watch_o),
    .wake_o(wake_any),
    .cause_o(unit_cause)
  );

  // Supply filter: glitches on the good level restart the count
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sup_cnt <= 4'h0;
      sup_good <= 1'b0;
    end else if (!supply_ok_i || brownout_i) begin
      sup_cnt <= 4'h0;
      sup_good <= 1'b0;
    end else if (sup_cnt == `PMS_SUP_FILT_CYC) begin
      sup_good <= 1'b1;
    end else begin
      sup_cnt <= sup_cnt + 4'h1;
    end
  end

  always @* begin
    next_state = state;
    case (state)
      ST_RESET: begin
        if (sup_good) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (cpu_idle_i && mode_req_i == `PMS_REQ_SLEEP) begin
          next_state = ST_SLEEP;
        end else if (cpu_idle_i && mode_req_i == `PMS_REQ_DEEP && !irq_hit) begin
          next_state = ST_DEEP;
        end
      end
      ST_SLEEP: begin
        if (irq_hit) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_DEEP: begin
        if (wake_any) begin
          next_state = ST_HS_START;
        end
      end
      ST_HS_START: begin
        if (hs_osc_ready_i && hs_cnt >= `PMS_HS_START_CYC) begin
          next_state = ST_RESTORE;
        end else if (wake_cnt >= WAKE_MAX - 12'h0004) begin
          // Latch, entry, restore and Active edges also count against the wake limit
          next_state = ST_RESTORE;
        end
      end
      ST_RESTORE: begin
        next_state = ST_ACTIVE;
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase
    // Raw supply status bypasses the filter so a brown-out resets on the next edge
    if (!sup_good || !supply_ok_i || brownout_i) begin
      next_state = ST_RESET;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_RESET;
      hs_cnt <= 12'h000;
      wake_cnt <= 12'h000;
    end else begin
      state <= next_state;
      if (state == ST_HS_START) begin
        hs_cnt <= hs_cnt + 12'h001;
        wake_cnt <= wake_cnt + 12'h001;
      end else begin
        hs_cnt <= 12'h000;
        wake_cnt <= 12'h000;
      end
    end
  end

  // Output decode registered from the next state so outputs change with it
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sys_rst_o <= 1'b1;
      cpu_clk_en_o <= 1'b0;
      periph_clk_en_o <= 1'b0;
      hs_osc_en_o <= 1'b0;
      lf_osc_en_o <= 1'b1;
      cpu_pwr_en_o <= 1'b0;
      addr_watch_o <= 1'b0;
      mode_o <= `PMS_MODE_ACTIVE;
      irq_pend_o <= {`PMS_NUM_IRQ{1'b0}};
      cpu_wake_o <= 1'b0;
      wake_cause_o <= {(`PMS_NUM_IRQ+1){1'b0}};
      wake_late_o <= 1'b0;
    end else begin
      sys_rst_o <= (next_state == ST_RESET);
      lf_osc_en_o <= 1'b1;
      irq_pend_o <= irq_i & irq_en_i;
      cpu_wake_o <= 1'b0;
      case (next_state)
        ST_ACTIVE: begin
          cpu_clk_en_o <= 1'b1;
          periph_clk_en_o <= 1'b1;
          hs_osc_en_o <= 1'b1;
          cpu_pwr_en_o <= 1'b1;
          addr_watch_o <= 1'b0;
          mode_o <= `PMS_MODE_ACTIVE;
          cpu_wake_o <= (state != ST_ACTIVE) && (state != ST_RESET);
        end
        ST_SLEEP: begin
          cpu_clk_en_o <= 1'b0;
          periph_clk_en_o <= 1'b1;
          hs_osc_en_o <= 1'b1;
          cpu_pwr_en_o <= 1'b1;
          addr_watch_o <= 1'b0;
          mode_o <= `PMS_MODE_SLEEP;
        end
        ST_DEEP: begin
          cpu_clk_en_o <= 1'b0;
          periph_clk_en_o <= 1'b0;
          hs_osc_en_o <= 1'b0;
          cpu_pwr_en_o <= 1'b0;
          addr_watch_o <= 1'b1;
          mode_o <= `PMS_MODE_DEEP;
        end
        ST_HS_START: begin
          cpu_clk_en_o <= 1'b0;
          periph_clk_en_o <= 1'b0;
          hs_osc_en_o <= 1'b1;
          cpu_pwr_en_o <= 1'b1;
          addr_watch_o <= 1'b1;
          mode_o <= `PMS_MODE_DEEP;
        end
        ST_RESTORE: begin
          cpu_clk_en_o <= 1'b0;
          periph_clk_en_o <= 1'b1;
          hs_osc_en_o <= 1'b1;
          cpu_pwr_en_o <= 1'b1;
          addr_watch_o <= 1'b0;
          mode_o <= `PMS_MODE_DEEP;
          wake_cause_o <= unit_cause;
          wake_late_o <= !hs_osc_ready_i;
        end
        default: begin
          cpu_clk_en_o <= 1'b0;
          periph_clk_en_o <= 1'b0;
          hs_osc_en_o <= 1'b0;
          cpu_pwr_en_o <= 1'b0;
          addr_watch_o <= 1'b0;
          mode_o <= `PMS_MODE_ACTIVE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== logic/pms_wake_unit.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pms_map.vh"
// Wake-up interrupt unit: runs on the always-on clock, latches any enabled
// request or address match while the main domain is down.
module pms_wake_unit (
  input wire clk_i,
  input wire rst_i,
  input wire watch_i,
  input wire clear_i,
  input wire [`PMS_NUM_IRQ-1:0] irq_i,
  input wire [`PMS_NUM_IRQ-1:0] irq_en_i,
  input wire addr_match_i,
  output reg wake_o,
  output reg [`PMS_NUM_IRQ:0] cause_o
);
  wire [`PMS_NUM_IRQ:0] src;
  assign src = {addr_match_i, irq_i & irq_en_i};
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_o <= 1'b0;
      cause_o <= {(`PMS_NUM_IRQ+1){1'b0}};
    end else if (watch_i && |src) begin
      // Set wins over a clear in the same cycle
      wake_o <= 1'b1;
      cause_o <= cause_o | src;
    end else if (clear_i || !watch_i) begin
      wake_o <= 1'b0;
      cause_o <= {(`PMS_NUM_IRQ+1){1'b0}};
    end
  end
endmodule
`default_nettype wire

// ==== shared/pms_map.vh ====
`ifndef PMS_MAP_VH
`define PMS_MAP_VH
// Mode codes reported on the mode output
`define PMS_MODE_ACTIVE 2'h0
`define PMS_MODE_SLEEP 2'h1
`define PMS_MODE_DEEP 2'h2
// Software request codes
`define PMS_REQ_NONE 2'h0
`define PMS_REQ_SLEEP 2'h1
`define PMS_REQ_DEEP 2'h2
// Interrupt request inputs
`define PMS_NUM_IRQ 8
// Clock rate in kHz and wake-up limit in ns
`define PMS_CLK_KHZ 50000
`define PMS_WAKE_MAX_NS 35000
// Longest time rounds down: 35000 ns at 20 ns = 1750 cycles
`define PMS_WAKE_MAX_CYC 12'h06D6
// High-speed clock start-up budget, well inside the wake limit
`define PMS_HS_START_CYC 12'h03E8
// Supply-good filter length in cycles
`define PMS_SUP_FILT_CYC 4'h8
`endif
